// file: design/bzd_top.sv
// buzzer square-wave driver with an APB register slave
// assumes: pclk is the main oscillator; sub_clock_sel comes from another domain
`timescale 1ns/1ps
`include "bzd_map.svh"
module bzd_top
(
  input wire logic pclk,
  input wire logic presetn,
  input bzd_pkg::bzd_apb_req_type apb_req,
  output bzd_pkg::bzd_apb_rsp_type apb_rsp,
  input wire logic sub_clock_sel,
  input wire logic port0_bit4_port_out,
  output logic port0_bit4_pin
);
  import bzd_pkg::*;
  bzd_state_type st_r;
  bzd_state_type st_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic tap;
  logic [3:0] tap_idx;
  logic ctrl_wr;
  logic func_wr;
  logic tick;

  function automatic logic is_reg(input logic [11:0] a);
    is_reg = (a == `BZD_OFS_CONTROL) || (a == `BZD_OFS_PORTFUNC) || (a == `BZD_OFS_STATUS);
  endfunction

  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign addr_ok = is_reg(apb_req.paddr);
  assign ctrl_wr = wr_en && (apb_req.paddr == `BZD_OFS_CONTROL);
  assign func_wr = wr_en && (apb_req.paddr == `BZD_OFS_PORTFUNC);
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
  assign apb_rsp.prdata = st_r.prdata;

  // prescaler taps: ratio 8 << cksel, sub clock adds seven more halvings
  assign tap_idx = 4'(`BZD_BASE_DIV_LOG2 - 1) + {2'h0, st_r.cksel}
                   + (st_r.sub_sync[1] ? 4'(`BZD_SUB_DIV_LOG2) : 4'h0);
  assign tap = st_r.presc[tap_idx];
  assign tick = st_r.presc_prev && !tap;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sub_sync = {st_r.sub_sync[0], sub_clock_sel};
    st_nxt.presc = st_r.presc + 14'h0001;
    st_nxt.presc_prev = tap;
    // falling edge of tap bit gives one tick per 2^(tap_idx+1) cycles
    if (tick)
    begin
      if (st_r.count == st_r.match)
      begin
        st_nxt.count = 6'h00;
        st_nxt.tone = !st_r.tone;
      end
      else
      begin
        st_nxt.count = st_r.count + 6'h01;
      end
    end
    if (ctrl_wr)
    begin
      st_nxt.match = apb_req.pwdata[`BZD_MATCH_MSB:`BZD_MATCH_LSB];
      st_nxt.cksel = apb_req.pwdata[`BZD_CKSEL_MSB:`BZD_CKSEL_LSB];
      st_nxt.count = 6'h00;
    end
    if (func_wr)
    begin
      st_nxt.pinen = apb_req.pwdata[`BZD_PINEN_BIT];
    end
    if (rd_en)
    begin
      case (apb_req.paddr)
        // control reads as zero: write-only
        `BZD_OFS_CONTROL: st_nxt.prdata = 32'h00000000;
        `BZD_OFS_PORTFUNC: st_nxt.prdata = {27'h0, st_r.pinen, 4'h0};
        `BZD_OFS_STATUS: st_nxt.prdata = {24'h0, st_r.tone, st_r.sub_sync[1], st_r.count};
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
    st_nxt.pin = st_nxt.pinen ? st_nxt.tone : port0_bit4_port_out;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.match <= `BZD_MATCH_RESET;
      st_r.cksel <= `BZD_CKSEL_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign port0_bit4_pin = st_r.pin;

  // check helper: bits up to the tap are all clear on a real tick
  function automatic logic [13:0] low_mask(input logic [3:0] k);
    low_mask = 14'((15'h0001 << (k + 4'h1)) - 15'h0001);
  endfunction

  // named steps of the tone sequence, shared by the checks below
  sequence seq_ctrl_write;
    ctrl_wr;
  endsequence

  sequence seq_tick_at_match;
    tick && (st_r.count == st_r.match) && !ctrl_wr;
  endsequence

  sequence seq_tick_below_match;
    tick && (st_r.count != st_r.match) && !ctrl_wr;
  endsequence

  // the select must hold its new level for two edges to pass the synchroniser
  sequence seq_sub_rise;
    $rose(sub_clock_sel) ##1 sub_clock_sel;
  endsequence

  // reset state
  property p_reset_match;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> st_r.match == `BZD_MATCH_RESET;
  endproperty
  chk_reset_match: assert property (p_reset_match)
  else
    $error("match reset wrong");

  property p_reset_state;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> st_r.cksel == `BZD_CKSEL_RESET && !st_r.pinen && !st_r.tone;
  endproperty
  chk_reset_state: assert property (p_reset_state)
  else
    $error("select or pin enable not reset");

  // control writes
  property p_write_clears;
    @(posedge pclk) disable iff (!presetn)
    seq_ctrl_write |=> st_r.count == 6'h00;
  endproperty
  chk_write_clears: assert property (p_write_clears)
  else
    $error("write did not clear counter");

  property p_write_match;
    @(posedge pclk) disable iff (!presetn)
    seq_ctrl_write |=> st_r.match == $past(apb_req.pwdata[`BZD_MATCH_MSB:`BZD_MATCH_LSB]);
  endproperty
  chk_write_match: assert property (p_write_match)
  else
    $error("match field not stored");

  property p_write_cksel;
    @(posedge pclk) disable iff (!presetn)
    seq_ctrl_write |=> st_r.cksel == $past(apb_req.pwdata[`BZD_CKSEL_MSB:`BZD_CKSEL_LSB]);
  endproperty
  chk_write_cksel: assert property (p_write_cksel)
  else
    $error("clock select not stored");

  // counter behaviour
  property p_count_bound;
    @(posedge pclk) disable iff (!presetn)
    st_r.count <= st_r.match;
  endproperty
  chk_count_bound: assert property (p_count_bound)
  else
    $error("count beyond match");

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    seq_tick_below_match |=> st_r.count == $past(st_r.count) + 6'h01;
  endproperty
  chk_count_step: assert property (p_count_step)
  else
    $error("count stepped wrong");

  property p_wrap_on_match;
    @(posedge pclk) disable iff (!presetn)
    seq_tick_at_match |=> st_r.count == 6'h00 && st_r.tone != $past(st_r.tone);
  endproperty
  chk_wrap_on_match: assert property (p_wrap_on_match)
  else
    $error("no wrap and toggle on match");

  property p_toggle_match;
    @(posedge pclk) disable iff (!presetn)
    $changed(st_r.tone) |-> $past(tick) && ($past(st_r.count) == $past(st_r.match));
  endproperty
  chk_toggle_match: assert property (p_toggle_match)
  else
    $error("tone toggled off match");

  property p_idle_hold;
    @(posedge pclk) disable iff (!presetn)
    !tick && !ctrl_wr |=> $stable(st_r.count) && $stable(st_r.tone);
  endproperty
  chk_idle_hold: assert property (p_idle_hold)
  else
    $error("counter moved without a tick");

  // prescaler ticks; a select change may give one stray tick, so it is excluded
  property p_tick_phase;
    @(posedge pclk) disable iff (!presetn)
    tick && $stable(tap_idx) |-> (st_r.presc & low_mask(tap_idx)) == 14'h0000;
  endproperty
  chk_tick_phase: assert property (p_tick_phase)
  else
    $error("tick off the prescaler period");

  property p_tick_due;
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && $stable(tap_idx) && (st_r.presc & low_mask(tap_idx)) == 14'h0000
      |-> tick;
  endproperty
  chk_tick_due: assert property (p_tick_due)
  else
    $error("prescaler tick missing");

  property p_tap_main;
    @(posedge pclk) disable iff (!presetn)
    !st_r.sub_sync[1] |-> tap_idx == 4'h2 + {2'h0, st_r.cksel};
  endproperty
  chk_tap_select: assert property (p_tap_main)
  else
    $error("prescaler tap wrong");

  property p_tap_sub;
    @(posedge pclk) disable iff (!presetn)
    st_r.sub_sync[1] |-> tap_idx == 4'h9 + {2'h0, st_r.cksel};
  endproperty
  chk_tap_sub: assert property (p_tap_sub)
  else
    $error("sub clock tap wrong");

  property p_sub_sync;
    @(posedge pclk) disable iff (!presetn)
    seq_sub_rise |-> ##1 st_r.sub_sync[1];
  endproperty
  chk_sub_sync: assert property (p_sub_sync)
  else
    $error("sub clock select not synchronised");

  // pin routing
  property p_func_write;
    @(posedge pclk) disable iff (!presetn)
    func_wr |=> st_r.pinen == $past(apb_req.pwdata[`BZD_PINEN_BIT]);
  endproperty
  chk_func_write: assert property (p_func_write)
  else
    $error("pin enable not stored");

  property p_pin_route;
    @(posedge pclk) disable iff (!presetn)
    st_r.pinen |-> port0_bit4_pin == st_r.tone;
  endproperty
  chk_pin_route: assert property (p_pin_route)
  else
    $error("pin not carrying tone");

  property p_pin_port;
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && !st_r.pinen |-> port0_bit4_pin == $past(port0_bit4_port_out);
  endproperty
  chk_pin_port: assert property (p_pin_port)
  else
    $error("pin not carrying port value");

  // register reads and unmapped writes
  property p_ctrl_readzero;
    @(posedge pclk) disable iff (!presetn)
    rd_en && apb_req.paddr == `BZD_OFS_CONTROL |=> st_r.prdata == 32'h00000000;
  endproperty
  chk_ctrl_readzero: assert property (p_ctrl_readzero)
  else
    $error("control readable");

  property p_func_read;
    @(posedge pclk) disable iff (!presetn)
    rd_en && apb_req.paddr == `BZD_OFS_PORTFUNC |=> st_r.prdata[`BZD_PINEN_BIT] == $past(st_r.pinen);
  endproperty
  chk_func_read: assert property (p_func_read)
  else
    $error("pin enable reads wrong");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    rd_en && apb_req.paddr == `BZD_OFS_STATUS
      |=> st_r.prdata[5:0] == $past(st_r.count) && st_r.prdata[7] == $past(st_r.tone);
  endproperty
  chk_status_read:  assert property (p_status_read)
  else
    $error("status reads wrong");

  property p_unmapped_write;
    @(posedge pclk) disable iff (!presetn)
    wr_en && !addr_ok |=> $stable(st_r.match) && $stable(st_r.cksel) && $stable(st_r.pinen);
  endproperty
  chk_unmapped_write: assert property (p_unmapped_write)
  else
    $error("unmapped write changed state");

  property p_read_hold;
    @(posedge pclk) disable iff (!presetn)
    !rd_en |=> $stable(st_r.prdata);
  endproperty
  chk_read_hold: assert property (p_read_hold)
  else
    $error("read data moved without a read");

endmodule // bzd_top

// file: design/bzd_map.svh
// register offsets, field positions, reset values and timing counts for the buzzer driver
// assumes: included by bare name from the top module
// Function
// - tone divider is a 6-bit up-counter with control register and clock selector
// - any write to the control register clears the tone counter to zero
// - counter increments from zero until it equals the 6-bit match field
// - on match the counter clears, output toggles, giving 50% duty square wave
// - after reset the match field holds 3F hex
// - control register is write-only; reads need not return its content
// - tone frequency is oscillator over two, prescaler ratio and match plus one
// - a 2-bit clock-select field chooses the prescaler output for the counter
// - tone reaches the shared pin only when the function select bit is 1
// - clock-select sits in bits 7:6; each higher code halves the frequency
// - with the sub clock as source, frequency is divided by a further 128
`ifndef BZD_MAP_SVH
`define BZD_MAP_SVH
`define BZD_OFS_CONTROL 12'h000
`define BZD_OFS_PORTFUNC 12'h004
`define BZD_OFS_STATUS 12'h008
`define BZD_MATCH_LSB 0
`define BZD_MATCH_MSB 5
`define BZD_CKSEL_LSB 6
`define BZD_CKSEL_MSB 7
`define BZD_PINEN_BIT 4
`define BZD_MATCH_RESET 6'h3F
`define BZD_CKSEL_RESET 2'h0
`define BZD_BASE_DIV_LOG2 3
`define BZD_SUB_DIV_LOG2 7
`endif

// file: design/bzd_pkg.sv
// types shared by the buzzer driver
// assumes: constants come from bzd_map.svh
package bzd_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bzd_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bzd_apb_rsp_type;
  typedef struct packed {
    logic [5:0] match;
    logic [1:0] cksel;
    logic pinen;
    logic [13:0] presc;
    logic presc_prev;
    logic [5:0] count;
    logic tone;
    logic [1:0] sub_sync;
    logic [31:0] prdata;
    logic pin;
  } bzd_state_type;
endpackage

// file: tb/bzd_buzzer.sv
// buzzer model: counts pclk cycles between pin edges
// assumes: the pin is sampled on pclk rising edges
`timescale 1ns/1ps
module bzd_buzzer
(
  input wire logic pclk,
  input wire logic pin,
  output int half_cycles
);
  logic last = 1'b0;
  int cnt = 0;
  initial half_cycles = 0;
  // a square wave shows equal gaps between edges
  always @(posedge pclk)
  begin
    last <= pin;
    cnt <= (pin != last) ? 1 : cnt + 1;
    if (pin != last)
      half_cycles <= cnt;
  end
endmodule // bzd_buzzer

// file: tb/bzd_top_bench.sv
// bench for the buzzer driver: apb tasks and tone period checks
// assumes: bzd_buzzer measures half periods on the pin
`timescale 1ns/1ps
module bzd_top_bench;
  import bzd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sub_sel = 1'b0;
  logic port_out = 1'b1;
  logic pin;
  logic err;
  logic [31:0] rd;
  int half;
  int errors = 0;
  int checked = 0;
  bzd_apb_req_type req = '0;
  bzd_apb_rsp_type rsp;
  always #25 pclk = ~pclk;
  bzd_top bzd_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .sub_clock_sel(sub_sel), .port0_bit4_port_out(port_out), .port0_bit4_pin(pin));
  bzd_buzzer bzd_buzzer_i (.pclk(pclk), .pin(pin), .half_cycles(half));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // first gap after a write has an arbitrary prescaler phase, so skip it
  task automatic tone(input logic [7:0] ctl, input int want);
    apb(1'b1, 12'h000, {24'h0, ctl});
    repeat (3) @(pin);
    repeat (2) @(posedge pclk);
    check(half, want);
  endtask
  task automatic wrap_up;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    errors++;
    wrap_up;
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    check(pin, 1'b1);
    apb(1'b0, 12'h0FC, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 12'h0FC, 32'hFF);
    check(err, 1'b1);
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h10);
    repeat (3) @(pin);
    repeat (2) @(posedge pclk);
    check(half, 512);
    for (int c = 0; c < 4; c++)
      tone({c[1:0], 6'h03}, 4 << (3 + c));
    tone(8'h40, 16);
    sub_sel <= 1'b1;
    tone(8'h00, 1024);
    port_out <= 1'b0;
    apb(1'b1, 12'h004, 32'h0);
    repeat (2) @(posedge pclk);
    check(pin, 1'b0);
    wrap_up;
  end
endmodule // bzd_top_bench
